// file: baud_tick.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick #(
    parameter int DIV_W = 16
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Sync reset
    input wire logic ce_i, // Clock enable
    input wire logic run_i, // Count while high
    input wire logic [DIV_W-1:0] divisor_i, // Period minus one
    output logic tick_o // One-cycle pulse
);
    if (DIV_W < 2 || DIV_W > 32) begin : g_chk
        $error("baud_tick: DIV_W out of range");
    end

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } baud_s;

    baud_s q;
    baud_s n;

    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (!run_i) begin
            n.cnt = divisor_i;
        end else if (q.cnt == '0) begin
            n.cnt = divisor_i;
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= n;
        end
    end

    assign tick_o = q.tick;
endmodule : baud_tick
`default_nettype wire

// file: serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int BIT_CYC = 4
) (
    input wire logic clk_i, // System clock
    input wire logic listen_i, // Decode async frames
    input wire logic clock_frame_i, // Clock one sync slave frame in
    input wire logic nine_i, // Nine data bits
    input wire logic data_i, // Data pin
    input wire logic data_oe_i, // Data pin driven
    output logic clk_pin_o, // Clock pin toward device
    output logic [8:0] char_o, // Last character
    output logic addr_o, // Last character marked address
    output logic [7:0] frames_o // Good frames seen
);
    logic line;
    logic ok;
    logic [8:0] sh;
    int n;
    // Pulled up while the device releases the pin
    assign line = data_oe_i ? data_i : 1'b1;
    initial begin
        char_o = '0;
        addr_o = 1'b0;
        frames_o = '0;
        // Clock stands at its idle low level outside sync frames
        clk_pin_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (listen_i && !line) begin
                repeat (BIT_CYC / 2) @(posedge clk_i);
                ok = !line;
                sh = '0;
                n = nine_i ? 9 : 8;
                for (int i = 0; i < n; i++) begin
                    repeat (BIT_CYC) @(posedge clk_i);
                    ok = ok && data_oe_i;
                    sh[i] = line;
                end
                repeat (BIT_CYC) @(posedge clk_i);
                // Released pin or missing stop bit drops the frame
                if (ok && line && data_oe_i) begin
                    char_o = sh;
                    addr_o = nine_i & sh[8];
                    frames_o++;
                end
            end else if (clock_frame_i) begin
                // Sample before each rise; device shifts after each fall
                ok = data_oe_i;
                sh = '0;
                n = nine_i ? 9 : 8;
                for (int i = 0; i < n; i++) begin
                    repeat (BIT_CYC) @(posedge clk_i);
                    ok = ok && data_oe_i;
                    sh[i] = line;
                    clk_pin_o <= 1'b1;
                    repeat (BIT_CYC) @(posedge clk_i);
                    clk_pin_o <= 1'b0;
                end
                repeat (BIT_CYC) @(posedge clk_i);
                // Device back at its idle high level after the last fall
                if (ok && line) begin
                    char_o = sh;
                    addr_o = nine_i & sh[8];
                    frames_o++;
                end
                while (clock_frame_i) @(posedge clk_i);
            end
        end
    end
endmodule : serial_peer
`default_nettype wire

// file: tx_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tx_link_if;
    logic [8:0] data;
    logic load;
    logic frame_nine;
    logic sync_mode;
    logic master;
    logic polarity;
    logic enable;
    logic port_on;
    logic tick;
    logic empty;
    modport ctrl (output data, load, frame_nine, sync_mode, master, polarity, enable,
        port_on, tick, input empty);
    modport shift (input data, load, frame_nine, sync_mode, master, polarity, enable,
        port_on, tick, output empty);
endinterface : tx_link_if
`default_nettype wire

// file: tx_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module tx_shifter (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Sync reset
    input wire logic ce_i, // Clock enable
    tx_link_if.shift lnk, // Control side
    input wire logic ext_clk_i, // Serial clock pin, slave mode
    output logic data_o, // Serial data pin
    output logic data_oe_o, // Serial data drive enable
    output logic clk_o, // Serial clock pin, master mode
    output logic clk_oe_o // Serial clock drive enable
);
    typedef struct packed {
        utx_pkg::shift_state_e st;
        logic [8:0] sh;
        logic [3:0] cnt;
        logic s1;
        logic s2;
        logic s3;
        logic ck;
        logic dout;
        logic doe;
        logic ckoe;
    } shift_s;

    shift_s q;
    shift_s n;
    logic active;
    logic step;
    logic [3:0] len;

    assign active = lnk.port_on & lnk.enable;
    assign len = lnk.frame_nine ? utx_pkg::LEN9 : utx_pkg::LEN8;

    always_comb begin
        n = q;
        n.s1 = ext_clk_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        // Shift on the edge back to idle level; async shifts each bit time
        if (!lnk.sync_mode) begin
            step = lnk.tick;
        end else if (lnk.master) begin
            step = lnk.tick & (q.ck != lnk.polarity);
        end else begin
            step = (q.s2 == lnk.polarity) && (q.s3 != lnk.polarity);
        end
        if (lnk.sync_mode && lnk.master && q.st != utx_pkg::SH_IDLE && lnk.tick) begin
            n.ck = ~q.ck;
        end
        unique case (q.st)
            utx_pkg::SH_IDLE: begin
                n.ck = lnk.polarity;
                n.dout = ~lnk.polarity;
                if (lnk.load) begin
                    n.st = utx_pkg::SH_DATA;
                    if (lnk.sync_mode) begin
                        n.dout = lnk.data[0];
                        n.sh = lnk.data >> 1;
                        n.cnt = len - 4'h1;
                    end else begin
                        n.dout = lnk.polarity;
                        n.sh = lnk.data;
                        n.cnt = len;
                    end
                end
            end
            utx_pkg::SH_DATA: begin
                if (step) begin
                    if (q.cnt == 4'h0) begin
                        n.st = lnk.sync_mode ? utx_pkg::SH_IDLE : utx_pkg::SH_STOP;
                        n.dout = ~lnk.polarity;
                    end else begin
                        n.dout = q.sh[0] ^ (~lnk.sync_mode & lnk.polarity);
                        n.sh = q.sh >> 1;
                        n.cnt = q.cnt - 4'h1;
                    end
                end
            end
            utx_pkg::SH_STOP: begin
                if (step) begin
                    n.st = utx_pkg::SH_IDLE;
                end
            end
            default: begin
                n.st = utx_pkg::SH_IDLE;
            end
        endcase
        if (!active) begin
            n.st = utx_pkg::SH_IDLE;
            n.dout = ~lnk.polarity;
            n.ck = lnk.polarity;
        end
        n.doe = active;
        n.ckoe = active & lnk.sync_mode & lnk.master;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= utx_pkg::SH_IDLE;
            q.dout <= 1'b1;
        end else if (ce_i) begin
            q <= n;
        end
    end

    assign lnk.empty = (q.st == utx_pkg::SH_IDLE);
    assign data_o = q.dout;
    assign data_oe_o = q.doe;
    assign clk_o = q.ck;
    assign clk_oe_o = q.ckoe;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i || !ce_i);

    sequence async_load_s;
        lnk.load && lnk.empty && active && !lnk.sync_mode;
    endsequence
    sequence sync_load_s;
        lnk.load && lnk.empty && active && lnk.sync_mode;
    endsequence

    frame_len_a: assert property (async_load_s ##0 lnk.frame_nine |=> q.cnt == 4'h9)
        else $error("nine-bit frame not loaded with nine bits");
    sync_first_a: assert property (sync_load_s |=> data_o == $past(lnk.data[0]))
        else $error("sync frame did not start with data bit");
    oe_force_a: assert property (active && !lnk.sync_mode |=> data_oe_o)
        else $error("data pin not driven in async transmit");
    master_clk_a: assert property (active && lnk.sync_mode |=> clk_oe_o == $past(lnk.master))
        else $error("clock pin drive does not follow source select");
endmodule : tx_shifter
`default_nettype wire

// file: usart_transmit_control.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module usart_transmit_control #(
    parameter int ADDR_W = utx_pkg::ADDR_W,
    parameter int DIV_W = 16
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Sync reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic awvalid_i, // AXI write address valid
    output logic awready_o, // AXI write address ready
    input wire logic [ADDR_W-1:0] awaddr_i, // AXI write address
    input wire logic wvalid_i, // AXI write data valid
    output logic wready_o, // AXI write data ready
    input wire logic [31:0] wdata_i, // AXI write data
    input wire logic [3:0] wstrb_i, // AXI byte strobes
    output logic bvalid_o, // AXI write response valid
    input wire logic bready_i, // AXI write response ready
    output logic [1:0] bresp_o, // AXI write response
    input wire logic arvalid_i, // AXI read address valid
    output logic arready_o, // AXI read address ready
    input wire logic [ADDR_W-1:0] araddr_i, // AXI read address
    output logic rvalid_o, // AXI read data valid
    input wire logic rready_i, // AXI read data ready
    output logic [31:0] rdata_o, // AXI read data
    output logic [1:0] rresp_o, // AXI read response
    input wire logic serial_clk_i, // Clock pin input
    output logic serial_data_o, // Data pin output
    output logic serial_data_oe_o, // Data pin drive enable
    output logic serial_clk_o, // Clock pin output
    output logic serial_clk_oe_o, // Clock pin drive enable
    output logic irq_o // Level interrupt
);
    if (ADDR_W < 12 || ADDR_W > 32 || DIV_W != 16) begin : g_chk
        $error("usart_transmit_control: unsupported ADDR_W or DIV_W");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_ok;
        logic w_ok;
        logic [9:0] aw_idx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] tsc;
        logic port_on;
        logic [15:0] baud;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [8:0] hold;
        logic hold_full;
        logic empty_q;
        logic flag;
        logic irq;
    } ctl_s;

    ctl_s q;
    ctl_s n;
    logic [1:0] set;
    logic [1:0] clr;
    logic wr_go;
    logic [9:0] ar_idx;

    tx_link_if lnk ();

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx == utx_pkg::TSC_IDX || idx == utx_pkg::DATA_IDX
            || idx == utx_pkg::PORT_IDX || idx == utx_pkg::BAUD_IDX
            || idx == utx_pkg::STAT_IDX || idx == utx_pkg::MASK_IDX;
    endfunction : is_mapped

    assign ar_idx = araddr_i[11:2];
    assign wr_go = q.aw_ok && q.w_ok && !q.bvalid;

    // Control fields steer the shifter
    assign lnk.data = q.hold;
    assign lnk.frame_nine = q.tsc[utx_pkg::NINE_POS];
    assign lnk.sync_mode = q.tsc[utx_pkg::MODE_POS];
    assign lnk.master = q.tsc[utx_pkg::CLK_SRC_POS];
    assign lnk.polarity = q.tsc[utx_pkg::POL_POS];
    assign lnk.enable = q.tsc[utx_pkg::TX_ENABLE_POS];
    assign lnk.port_on = q.port_on;
    assign lnk.load = q.hold_full & lnk.empty & q.tsc[utx_pkg::TX_ENABLE_POS] & q.port_on;

    always_comb begin
        n = q;
        set = 2'h0;
        clr = 2'h0;
        if (awvalid_i && q.awready) begin
            n.aw_ok = 1'b1;
            n.aw_idx = awaddr_i[11:2];
        end
        if (wvalid_i && q.wready) begin
            n.w_ok = 1'b1;
            n.wdata = wdata_i;
            n.wstrb = wstrb_i;
        end
        if (q.bvalid && bready_i) begin
            n.bvalid = 1'b0;
        end
        if (lnk.load) begin
            n.hold_full = 1'b0;
        end
        if (wr_go) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = is_mapped(q.aw_idx) ? utx_pkg::RESP_OKAY : utx_pkg::RESP_SLVERR;
            if (q.wstrb[0]) begin
                case (q.aw_idx)
                    utx_pkg::TSC_IDX: begin
                        n.tsc = q.wdata[7:0] & utx_pkg::TSC_RW_MASK;
                    end
                    utx_pkg::DATA_IDX: begin
                        // Ninth bit taken from the control register at this write
                        if (!q.hold_full) begin
                            n.hold = {q.tsc[utx_pkg::D9_POS], q.wdata[7:0]};
                            n.hold_full = 1'b1;
                        end
                    end
                    utx_pkg::PORT_IDX: begin
                        n.port_on = q.wdata[0];
                    end
                    utx_pkg::BAUD_IDX: begin
                        n.baud[7:0] = q.wdata[7:0];
                    end
                    utx_pkg::STAT_IDX: begin
                        clr = q.wdata[1:0];
                    end
                    utx_pkg::MASK_IDX: begin
                        n.mask = q.wdata[1:0];
                    end
                    default: begin
                        n.mask = q.mask;
                    end
                endcase
            end
            if (q.wstrb[1] && q.aw_idx == utx_pkg::BAUD_IDX) begin
                n.baud[15:8] = q.wdata[15:8];
            end
        end
        if (q.rvalid && rready_i) begin
            n.rvalid = 1'b0;
        end
        if (arvalid_i && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = 32'h0000_0000;
            n.rresp = is_mapped(ar_idx) ? utx_pkg::RESP_OKAY : utx_pkg::RESP_SLVERR;
            case (ar_idx)
                utx_pkg::TSC_IDX: begin
                    n.rdata[7:0] = {q.tsc[7:2], lnk.empty, q.tsc[0]};
                end
                utx_pkg::DATA_IDX: begin
                    n.rdata[8:0] = q.hold;
                end
                utx_pkg::PORT_IDX: begin
                    n.rdata[0] = q.port_on;
                end
                utx_pkg::BAUD_IDX: begin
                    n.rdata[15:0] = q.baud;
                end
                utx_pkg::STAT_IDX: begin
                    n.rdata[1:0] = q.stat;
                end
                utx_pkg::MASK_IDX: begin
                    n.rdata[1:0] = q.mask;
                end
                default: begin
                    n.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Disabling flushes any pending character
        if (!n.tsc[utx_pkg::TX_ENABLE_POS] || !n.port_on) begin
            n.hold_full = 1'b0;
        end
        n.empty_q = lnk.empty;
        n.flag = n.tsc[utx_pkg::TX_ENABLE_POS] & ~n.hold_full;
        set[utx_pkg::EV_BUF_POS] = n.flag & ~q.flag;
        set[utx_pkg::EV_DONE_POS] = lnk.empty & ~q.empty_q;
        // Set wins over a same-cycle clear
        n.stat = (q.stat & ~clr) | set;
        n.irq = |(n.stat & n.mask);
        n.awready = !n.aw_ok && !n.bvalid;
        n.wready = !n.w_ok && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.tsc <= utx_pkg::TSC_RESET;
            q.baud <= utx_pkg::BAUD_RESET;
            q.empty_q <= 1'b1;
        end else if (ce_i) begin
            q <= n;
        end
    end

    baud_tick #(
        .DIV_W(DIV_W)
    ) baud_tick_i (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .run_i(!lnk.empty),
        .divisor_i(q.baud),
        .tick_o(lnk.tick)
    );

    tx_shifter tx_shifter_i (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .lnk(lnk),
        .ext_clk_i(serial_clk_i),
        .data_o(serial_data_o),
        .data_oe_o(serial_data_oe_o),
        .clk_o(serial_clk_o),
        .clk_oe_o(serial_clk_oe_o)
    );

    assign awready_o = q.awready;
    assign wready_o = q.wready;
    assign bvalid_o = q.bvalid;
    assign bresp_o = q.bresp;
    assign arready_o = q.arready;
    assign rvalid_o = q.rvalid;
    assign rdata_o = q.rdata;
    assign rresp_o = q.rresp;
    assign irq_o = q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i || !ce_i);

    sequence tsc_enable_write_s;
        wr_go && q.aw_idx == utx_pkg::TSC_IDX && q.wstrb[0]
            && q.wdata[utx_pkg::TX_ENABLE_POS] && !q.tsc[utx_pkg::TX_ENABLE_POS];
    endsequence
    sequence tsc_read_s;
        arvalid_i && q.arready && ar_idx == utx_pkg::TSC_IDX;
    endsequence

    enable_flag_a: assert property (tsc_enable_write_s |=> q.flag && q.stat[utx_pkg::EV_BUF_POS])
        else $error("enabling transmit did not raise buffer flag");
    off_flush_a: assert property (!q.tsc[utx_pkg::TX_ENABLE_POS] |=> !q.hold_full)
        else $error("character held while transmit disabled");
    empty_read_a: assert property (tsc_read_s |=> rvalid_o && rdata_o[utx_pkg::EMPTY_POS] == $past(lnk.empty))
        else $error("empty bit read does not follow shifter");
    unmapped_err_a: assert property (wr_go && !is_mapped(q.aw_idx) |=> bvalid_o && bresp_o == utx_pkg::RESP_SLVERR)
        else $error("unmapped write not answered with error");
endmodule : usart_transmit_control
`default_nettype wire

// file: usart_transmit_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usart_transmit_control_tb;
    logic clk_i, sys_rst_i, ce_i, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, irq, ext_clk;
    logic sdata, sdata_oe, sclk, sclk_oe, sclk_q, listen, nine, paddr, sync_clk;
    logic [1:0] bresp, rresp, resp, bexp;
    logic [8:0] pchar;
    logic [7:0] frames;
    int err_count, checks, clk_rises;

    usart_transmit_control usart_transmit_control_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
        .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb),
        .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
        .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
        .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp),
        .serial_clk_i(ext_clk), .serial_data_o(sdata), .serial_data_oe_o(sdata_oe),
        .serial_clk_o(sclk), .serial_clk_oe_o(sclk_oe), .irq_o(irq)
    );
    serial_peer #(.BIT_CYC(4)) serial_peer_i (
        .clk_i(clk_i), .listen_i(listen), .clock_frame_i(sync_clk), .nine_i(nine),
        .data_i(sdata),
        .data_oe_i(sdata_oe), .clk_pin_o(ext_clk), .char_o(pchar),
        .addr_o(paddr), .frames_o(frames)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        sclk_q <= sclk;
        if (sclk === 1'b1 && sclk_q === 1'b0) clk_rises++;
    end

    task automatic wrap_up;
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit
    task automatic axi_wr(input logic [9:0] idx, input logic [31:0] d);
        int n;
        logic aw_left, w_left, got;
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        got = 1'b0;
        n = 0;
        while (!got && n < 200) begin
            @(posedge clk_i);
            n++;
            if (aw_left && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
            if (bvalid === 1'b1 && !aw_left && !w_left) begin
                got = 1'b1;
                cmp_word({30'h0, bresp}, {30'h0, bexp});
            end
        end
        if (!got) err_count++;
    endtask : axi_wr
    task automatic axi_rd(input logic [9:0] idx);
        int n;
        logic a_left, got;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        a_left = 1'b1;
        got = 1'b0;
        n = 0;
        while (!got && n < 200) begin
            @(posedge clk_i);
            n++;
            if (a_left && arready === 1'b1) begin
                arvalid <= 1'b0;
                a_left = 1'b0;
            end
            if (rvalid === 1'b1 && !a_left) begin
                got = 1'b1;
                rd = rdata;
                resp = rresp;
            end
        end
        if (!got) err_count++;
    endtask : axi_rd
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        axi_rd(idx);
        cmp_word(rd & m, e);
        cmp_word({30'h0, resp}, {30'h0, er});
    endtask : rd_chk
    task automatic wait_frames(input logic [7:0] target);
        int n;
        n = 0;
        while (frames !== target && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        cmp_word({24'h0, frames}, {24'h0, target});
    endtask : wait_frames
    task automatic poll_empty;
        int n;
        n = 0;
        do begin
            axi_rd(utx_pkg::TSC_IDX);
            n++;
        end while (rd[1] !== 1'b1 && n < 100);
        cmp_bit(rd[1], 1'b1);
    endtask : poll_empty

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end

    initial begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        {awvalid, wvalid, arvalid, listen, nine, sync_clk} = '0;
        // Response readies stay high, so no task lowers and raises them in one step
        {bready, rready} = 2'b11;
        bexp = utx_pkg::RESP_OKAY;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        err_count = 0;
        checks = 0;
        clk_rises = 0;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(utx_pkg::TSC_IDX, 32'h0000_00FF, 32'h0000_0002, utx_pkg::RESP_OKAY);
        rd_chk(10'h118, 32'hFFFF_FFFF, 32'h0000_0000, utx_pkg::RESP_SLVERR);
        rd_chk(utx_pkg::BAUD_IDX, 32'h0000_FFFF, {16'h0000, utx_pkg::BAUD_RESET},
            utx_pkg::RESP_OKAY);
        bexp = utx_pkg::RESP_SLVERR;
        axi_wr(10'h118, 32'h0000_00FF);
        bexp = utx_pkg::RESP_OKAY;
        cmp_bit(sdata_oe, 1'b0);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_00FF);
        rd_chk(utx_pkg::TSC_IDX, 32'h0000_00FF, 32'h0000_00FF, utx_pkg::RESP_OKAY);
        cmp_bit(irq, 1'b0);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0000);
        rd_chk(utx_pkg::TSC_IDX, 32'h0000_00FF, 32'h0000_0002, utx_pkg::RESP_OKAY);
        axi_wr(utx_pkg::STAT_IDX, 32'h0000_0003);
        // Async port, short bit time, buffer event unmasked
        axi_wr(utx_pkg::PORT_IDX, 32'h0000_0001);
        axi_wr(utx_pkg::BAUD_IDX, 32'h0000_0003);
        axi_wr(utx_pkg::MASK_IDX, 32'h0000_0001);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0020);
        repeat (3) @(posedge clk_i);
        cmp_bit(irq, 1'b1);
        rd_chk(utx_pkg::STAT_IDX, 32'h0000_0001, 32'h0000_0001, utx_pkg::RESP_OKAY);
        cmp_bit(sdata_oe, 1'b1);
        cmp_bit(sclk_oe, 1'b0);
        axi_wr(utx_pkg::STAT_IDX, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        cmp_bit(irq, 1'b0);
        listen <= 1'b1;
        axi_wr(utx_pkg::DATA_IDX, 32'h0000_00A5);
        rd_chk(utx_pkg::TSC_IDX, 32'h0000_0002, 32'h0000_0000, utx_pkg::RESP_OKAY);
        wait_frames(8'h01);
        cmp_word({23'h0, pchar}, 32'h0000_00A5);
        poll_empty();
        rd_chk(utx_pkg::STAT_IDX, 32'h0000_0002, 32'h0000_0002, utx_pkg::RESP_OKAY);
        // Ninth bit loaded before the low byte, marking an address
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0061);
        nine <= 1'b1;
        axi_wr(utx_pkg::DATA_IDX, 32'h0000_003C);
        wait_frames(8'h02);
        cmp_word({23'h0, pchar}, 32'h0000_013C);
        cmp_bit(paddr, 1'b1);
        poll_empty();
        // Disable in mid-frame: frame dropped, buffer flushed
        nine <= 1'b0;
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0020);
        axi_wr(utx_pkg::DATA_IDX, 32'h0000_0055);
        repeat (8) @(posedge clk_i);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        cmp_bit(sdata_oe, 1'b0);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0020);
        repeat (80) @(posedge clk_i);
        cmp_word({24'h0, frames}, 32'h0000_0002);
        // Sync master mode drives its own clock
        listen <= 1'b0;
        clk_rises = 0;
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_00B0);
        repeat (2) @(posedge clk_i);
        cmp_bit(sclk_oe, 1'b1);
        axi_wr(utx_pkg::DATA_IDX, 32'h0000_0081);
        poll_empty();
        cmp_word(32'(clk_rises), 32'h0000_0008);
        axi_wr(utx_pkg::TSC_IDX, 32'h0000_0030);
        repeat (2) @(posedge clk_i);
        cmp_bit(sclk_oe, 1'b0);
        // Sync slave mode shifts on the peer's clock
        axi_wr(utx_pkg::DATA_IDX, 32'h0000_00C6);
        sync_clk <= 1'b1;
        wait_frames(8'h03);
        sync_clk <= 1'b0;
        cmp_word({23'h0, pchar}, 32'h0000_00C6);
        poll_empty();
        // Reset in mid-run restores the control register
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(utx_pkg::TSC_IDX, 32'h0000_00FF, 32'h0000_0002, utx_pkg::RESP_OKAY);
        cmp_bit(sdata_oe, 1'b0);
        wrap_up();
    end
endmodule : usart_transmit_control_tb
`default_nettype wire

// file: utx_pkg.sv
`default_nettype none
package utx_pkg;
    localparam int ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [9:0] TSC_IDX = 10'h117;
    localparam logic [9:0] DATA_IDX = 10'h119;
    localparam logic [9:0] PORT_IDX = 10'h11A;
    localparam logic [9:0] BAUD_IDX = 10'h11B;
    localparam logic [9:0] STAT_IDX = 10'h11C;
    localparam logic [9:0] MASK_IDX = 10'h11D;
    // Fields of transmit_status_control
    localparam int CLK_SRC_POS = 7;
    localparam int NINE_POS = 6;
    localparam int TX_ENABLE_POS = 5;
    localparam int MODE_POS = 4;
    localparam int POL_POS = 3;
    localparam int STOP_OPT_POS = 2;
    localparam int EMPTY_POS = 1;
    localparam int D9_POS = 0;
    localparam logic [7:0] TSC_RESET = 8'h02;
    localparam logic [7:0] TSC_RW_MASK = 8'hFD;
    localparam logic [15:0] BAUD_RESET = 16'h0067;
    // Event bits of status and mask
    localparam int EV_BUF_POS = 0;
    localparam int EV_DONE_POS = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] LEN9 = 4'h9;
    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_DATA = 3'b010,
        SH_STOP = 3'b100
    } shift_state_e;
endpackage : utx_pkg
`default_nettype wire
